// File: core/hcsg_pkg.sv
// Shared constants for the hub configuration stop-grant and memory frequency block
package hcsg_pkg;
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 16;
   localparam logic [7:0]  CFG_OFFSET      = 8'hc6;
   localparam logic [15:0] CFG_RESET       = 16'h0000;
   localparam int          NSG_MSB         = 15;
   localparam int          NSG_LSB         = 13;
   localparam int          MFREQ_MSB       = 11;
   localparam int          MFREQ_LSB       = 10;
   localparam logic [15:0] CFG_WRITE_MASK  = 16'he020;
   localparam logic [15:0] CFG_FIELD_MASK  = 16'hec20;
   localparam int          ROUTE_BIT       = 5;
   localparam logic [2:0]  NSG_ONE         = 3'h0;
   localparam logic [2:0]  NSG_TWO         = 3'h1;
   localparam logic [1:0]  MFREQ_RESET     = 2'h0;
   localparam logic [1:0]  MFREQ_333       = 2'h1;
   localparam logic [1:0]  MFREQ_400       = 2'h2;
   localparam int          SOURCE_W        = 4;
   localparam int          CNT_W           = 2;
endpackage

// File: core/hcsg_stop_grant_counter.sv
// Counts stop grant cycles and raises an acknowledge request held until ackReady
`timescale 1ns/1ps
module hcsg_stop_grant_counter #(
   parameter int SOURCES = hcsg_pkg::SOURCE_W
) (
   input  wire logic               mclk,
   input  wire logic               reset_n,
   input  wire logic [2:0]         countSelect,
   input  wire logic [SOURCES-1:0] stopGrantSeen,
   input  wire logic               ackReady,
   output logic                    ackValid,
   output logic [hcsg_pkg::CNT_W-1:0] countValue
);
   logic [hcsg_pkg::CNT_W-1:0] count_q;
   logic [hcsg_pkg::CNT_W-1:0] need;
   logic [hcsg_pkg::CNT_W-1:0] hits;
   logic [hcsg_pkg::CNT_W:0]   total;
   logic                       pend_q;

   // Reserved codes fall back to a single stop grant
   always_comb begin
      need = (countSelect == hcsg_pkg::NSG_TWO) ? 2'h2 : 2'h1;
   end

   // Each thread is its own source; simultaneous hits count up to three
   always_comb begin
      hits = 2'h0;
      for (int i = 0; i < SOURCES; i++) begin
         if (stopGrantSeen[i] && hits != 2'h3) begin
            hits = hits + 2'h1;
         end
      end
      total = {1'b0, count_q} + {1'b0, hits};
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         count_q <= 2'h0;
         pend_q  <= 1'b0;
      end else if (pend_q) begin
         // Counting paused until the packet leaves
         if (ackReady) begin
            pend_q  <= 1'b0;
            count_q <= 2'h0;
         end
      end else if (total >= {1'b0, need}) begin
         pend_q  <= 1'b1;
         count_q <= 2'h0;
      end else begin
         count_q <= total[hcsg_pkg::CNT_W-1:0];
      end
   end

   assign ackValid   = pend_q;
   assign countValue = count_q;
endmodule

// File: core/hub_config_stop_grant_memfreq.sv
// Memory hub configuration register with stop-grant counting and memory frequency select
`timescale 1ns/1ps
// Overview of operation
// - Acknowledge sent after programmed stop-grant count
// - Code 000 one grant, 001 two
// - Each thread counts separately, up to three per cycle
// - Memory frequency field resets to 00
// - Code 01 selects 333 MHz DDR
module hub_config_stop_grant_memfreq #(
   parameter int SOURCES = hcsg_pkg::SOURCE_W
) (
   input  wire logic                        mclk,
   input  wire logic                        reset_n,
   input  wire logic [hcsg_pkg::ADDR_W-1:0] regAddr,
   input  wire logic [hcsg_pkg::DATA_W-1:0] regWdata,
   input  wire logic                        regWrite,
   input  wire logic                        regRead,
   output logic      [hcsg_pkg::DATA_W-1:0] regRdata,
   input  wire logic [SOURCES-1:0]          stopGrantIn,
   input  wire logic                        hubLinkReady,
   output logic                             hubLinkStopGrantAck,
   input  wire logic                        clockSyncDone,
   input  wire logic                        hostBusFrequency,
   output logic      [1:0]                  memoryFrequencyActive,
   output logic                             memoryRate320,
   output logic                             mdaRouteEnable
);
   // Field widths follow the bit positions of the register
   localparam int NSG_W   = hcsg_pkg::NSG_MSB - hcsg_pkg::NSG_LSB + 1;
   localparam int MFREQ_W = hcsg_pkg::MFREQ_MSB - hcsg_pkg::MFREQ_LSB + 1;

   logic [NSG_W-1:0]            countSel_q;
   logic [NSG_W-1:0]            countSel_d;
   logic [MFREQ_W-1:0]          freqSel_q;
   logic [MFREQ_W-1:0]          freqSel_d;
   logic                        routeEn_q;
   logic                        routeEn_d;
   logic [MFREQ_W-1:0]          applied_q;
   logic [MFREQ_W-1:0]          applied_d;
   logic                        rate320_q;
   logic                        rate320_d;
   logic [hcsg_pkg::DATA_W-1:0] rdata_q;
   logic [hcsg_pkg::DATA_W-1:0] rdata_d;
   logic [hcsg_pkg::DATA_W-1:0] cfgView;
   logic [SOURCES-1:0]          sgMeta_q;
   logic [SOURCES-1:0]          sgSync_q;
   logic                        csMeta_q;
   logic                        csSync_q;
   logic                        csPrev_q;
   logic                        csRise;
   logic                        hbMeta_q;
   logic                        hbSync_q;
   logic                        wrHit;
   logic                        rdHit;
   logic                        rate333Sel;

   // Register decode, shared by the read and write paths
   function automatic logic hit(input logic [hcsg_pkg::ADDR_W-1:0] a);
      hit = (a == hcsg_pkg::CFG_OFFSET);
   endfunction

   // Unimplemented and reserved bits always read as zero
   function automatic logic [hcsg_pkg::DATA_W-1:0] cfgImage(
      input logic [NSG_W-1:0]   cnt,
      input logic [MFREQ_W-1:0] freq,
      input logic               route
   );
      cfgImage                                         = '0;
      cfgImage[hcsg_pkg::NSG_MSB:hcsg_pkg::NSG_LSB]     = cnt;
      cfgImage[hcsg_pkg::MFREQ_MSB:hcsg_pkg::MFREQ_LSB] = freq;
      cfgImage[hcsg_pkg::ROUTE_BIT]                    = route;
      cfgImage                                         = cfgImage & hcsg_pkg::CFG_FIELD_MASK;
   endfunction

   // Grant lines come from the processor side, asynchronous here
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         sgMeta_q <= '0;
         sgSync_q <= '0;
      end else begin
         sgMeta_q <= stopGrantIn;
         sgSync_q <= sgMeta_q;
      end
   end

   // Sync completion arrives from the clocking logic
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         csMeta_q <= 1'b0;
         csSync_q <= 1'b0;
      end else begin
         csMeta_q <= clockSyncDone;
         csSync_q <= csMeta_q;
      end
   end

   // Previous value, so a long sync pulse applies only once
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         csPrev_q <= 1'b0;
      end else begin
         csPrev_q <= csSync_q;
      end
   end

   // Host bus setting is a strap from another domain
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         hbMeta_q <= 1'b0;
         hbSync_q <= 1'b0;
      end else begin
         hbMeta_q <= hostBusFrequency;
         hbSync_q <= hbMeta_q;
      end
   end

   always_comb begin
      wrHit      = regWrite && hit(regAddr);
      rdHit      = regRead && hit(regAddr);
      csRise     = csSync_q && !csPrev_q;
      rate333Sel = (applied_q == hcsg_pkg::MFREQ_333);
      cfgView    = cfgImage(countSel_q, freqSel_q, routeEn_q);
   end

   // Count field is expected to stay fixed once stop-clock is on
   always_comb begin
      countSel_d = countSel_q;
      freqSel_d  = freqSel_q;
      routeEn_d  = routeEn_q;
      if (wrHit) begin
         countSel_d = regWdata[hcsg_pkg::NSG_MSB:hcsg_pkg::NSG_LSB];
         freqSel_d  = regWdata[hcsg_pkg::MFREQ_MSB:hcsg_pkg::MFREQ_LSB];
         routeEn_d  = regWdata[hcsg_pkg::ROUTE_BIT];
      end
   end

   always_comb begin
      applied_d = applied_q;
      if (csRise) begin
         applied_d = freqSel_q;
      end
      // Slower host bus setting pulls the 333 rate down to 320
      rate320_d = rate333Sel && hbSync_q;
   end

   always_comb begin
      rdata_d = '0;
      if (rdHit) begin
         rdata_d = cfgView;
      end
   end

   // Stop-grant count, handed to the counter as a level
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         countSel_q <= hcsg_pkg::CFG_RESET[hcsg_pkg::NSG_MSB:hcsg_pkg::NSG_LSB];
      end else begin
         countSel_q <= countSel_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         freqSel_q <= hcsg_pkg::MFREQ_RESET;
      end else begin
         freqSel_q <= freqSel_d;
      end
   end

   // Routing bit is only stored here; its decode lives elsewhere
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         routeEn_q <= hcsg_pkg::CFG_RESET[hcsg_pkg::ROUTE_BIT];
      end else begin
         routeEn_q <= routeEn_d;
      end
   end

   // Programmed frequency only takes effect on a sync completion edge
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         applied_q <= hcsg_pkg::MFREQ_RESET;
      end else begin
         applied_q <= applied_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rate320_q <= 1'b0;
      end else begin
         rate320_q <= rate320_d;
      end
   end

   // Read data stands for the one cycle after the strobe only
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   hcsg_stop_grant_counter #(
      .SOURCES (SOURCES)
   ) u_counter (
      .mclk          (mclk),
      .reset_n       (reset_n),
      .countSelect   (countSel_q),
      .stopGrantSeen (sgSync_q),
      .ackReady      (hubLinkReady),
      .ackValid      (hubLinkStopGrantAck),
      .countValue    ()
   );

   assign regRdata              = rdata_q;
   assign memoryFrequencyActive = applied_q;
   assign memoryRate320         = rate320_q;
   assign mdaRouteEnable        = routeEn_q;
endmodule

// File: sim/hcsg_checker_sva.sv
// Port checks for the hub configuration block
`timescale 1ns/1ps
module hcsg_checker #(
   parameter int SOURCES = 4
) (
   input wire logic               mclk,
   input wire logic               reset_n,
   input wire logic [SOURCES-1:0] stopGrantIn,
   input wire logic               hubLinkReady,
   input wire logic               hubLinkStopGrantAck,
   input wire logic               clockSyncDone,
   input wire logic [1:0]         memoryFrequencyActive,
   input wire logic               memoryRate320
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   sequence ackWait; hubLinkStopGrantAck && !hubLinkReady; endsequence
   sequence ackTaken; hubLinkStopGrantAck && hubLinkReady; endsequence
   a_ack_holds: assert property (ackWait |=> hubLinkStopGrantAck) else $error("ack dropped");
   a_ack_clears: assert property (ackTaken |=> !hubLinkStopGrantAck) else $error("ack stuck");
   a_ack_cause: assert property ($rose(hubLinkStopGrantAck) |-> $past(stopGrantIn, 3) != '0)
      else $error("ack without grant");
   a_ack_released: assert property ($fell(hubLinkStopGrantAck) |-> $past(hubLinkReady)) else $error("ack lost");
   a_freq_reset: assert property ($rose(reset_n) |-> memoryFrequencyActive == 2'h0) else $error("freq reset");
   a_freq_sync: assert property ($changed(memoryFrequencyActive) |-> $past(clockSyncDone, 3))
      else $error("freq moved unsynced");
   a_rate_cause: assert property (memoryRate320 |-> $past(memoryFrequencyActive) == 2'h1) else $error("rate");
endmodule
bind hub_config_stop_grant_memfreq hcsg_checker #(.SOURCES(SOURCES)) chk (.mclk(mclk), .reset_n(reset_n),
   .stopGrantIn(stopGrantIn), .hubLinkReady(hubLinkReady), .hubLinkStopGrantAck(hubLinkStopGrantAck),
   .clockSyncDone(clockSyncDone), .memoryFrequencyActive(memoryFrequencyActive), .memoryRate320(memoryRate320));

// File: sim/hcsg_hub_link_model.sv
// Hub link receiver taking the acknowledge after a chosen wait
`timescale 1ns/1ps
module hcsg_hub_link_model (
   input  wire logic       mclk,
   input  wire logic       ackValid,
   input  wire logic [3:0] waitCycles,
   output logic            ready
);
   logic [3:0] waited_q = 4'h0;
   always_ff @(posedge mclk) begin
      waited_q <= (ackValid && !ready) ? waited_q + 4'h1 : 4'h0;
   end
   // Never idle-high, so a stuck ack is seen
   assign ready = ackValid && (waited_q >= waitCycles);
endmodule

// File: sim/hub_config_stop_grant_memfreq_bench.sv
// Self-checking bench for the hub configuration block
`timescale 1ns/1ps
module hub_config_stop_grant_memfreq_bench;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [15:0] regWdata = 16'h0000;
   logic        regWrite = 1'b0;
   logic        regRead = 1'b0;
   logic [15:0] regRdata;
   logic [3:0]  stopGrantIn = 4'h0;
   logic        hubLinkReady;
   logic        ack;
   logic        clockSyncDone = 1'b0;
   logic        hostBusFrequency = 1'b0;
   logic [1:0]  freq;
   logic        rate320;
   logic        route;
   logic [3:0]  waitCycles = 4'h0;
   int          err_total = 0;
   int          checked = 0;
   int          cycles = 0;
   always #5 mclk = ~mclk;
   hub_config_stop_grant_memfreq dut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
      .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .stopGrantIn(stopGrantIn),
      .hubLinkReady(hubLinkReady), .hubLinkStopGrantAck(ack), .clockSyncDone(clockSyncDone),
      .hostBusFrequency(hostBusFrequency), .memoryFrequencyActive(freq), .memoryRate320(rate320),
      .mdaRouteEnable(route));
   hcsg_hub_link_model link (.mclk(mclk), .ackValid(ack), .waitCycles(waitCycles), .ready(hubLinkReady));
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
      @(posedge mclk);
      regWrite <= wr;
      regRead <= !wr;
      regAddr <= a;
      regWdata <= d;
      @(posedge mclk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      #1;
   endtask
   task automatic grant(input logic [3:0] bits, input logic exp);
      int n;
      @(posedge mclk);
      stopGrantIn <= bits;
      @(posedge mclk);
      stopGrantIn <= 4'h0;
      for (n = 0; n < 8 && ack !== 1'b1; n++) begin
         @(posedge mclk);
         #1;
      end
      check({15'h0, ack}, {15'h0, exp});
      repeat (20) @(posedge mclk);
      #1;
      check({15'h0, ack}, 16'h0000);
   endtask
   task automatic test_reset();
      access(1'b1, 8'hc4, 16'hffff);
      access(1'b0, 8'hc4, 16'h0000);
      check(regRdata, 16'h0000);
      access(1'b0, 8'hc6, 16'h0000);
      check(regRdata, 16'h0000);
      check({14'h0, freq}, 16'h0000);
   endtask
   task automatic test_one();
      grant(4'h1, 1'b1);
      grant(4'h8, 1'b1);
   endtask
   task automatic test_two();
      waitCycles <= 4'h5;
      access(1'b1, 8'hc6, 16'h2000);
      access(1'b0, 8'hc6, 16'h0000);
      check(regRdata, 16'h2000);
      grant(4'h2, 1'b0);
      grant(4'h4, 1'b1);
      grant(4'h3, 1'b1);
      grant(4'h1, 1'b0);
      grant(4'h1, 1'b1);
   endtask
   task automatic test_freq();
      hostBusFrequency <= 1'b1;
      access(1'b1, 8'hc6, 16'h17ff);
      access(1'b0, 8'hc6, 16'h0000);
      check(regRdata, 16'h0420);
      check({15'h0, route}, 16'h0001);
      repeat (6) @(posedge mclk);
      #1;
      check({14'h0, freq}, 16'h0000);
      clockSyncDone <= 1'b1;
      repeat (4) @(posedge mclk);
      clockSyncDone <= 1'b0;
      repeat (8) @(posedge mclk);
      #1;
      check({14'h0, freq}, 16'h0001);
      check({15'h0, rate320}, 16'h0001);
      hostBusFrequency <= 1'b0;
      repeat (6) @(posedge mclk);
      #1;
      check({15'h0, rate320}, 16'h0000);
      check({14'h0, freq}, 16'h0001);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         conclude();
      end
   end
   initial begin
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      test_reset();
      test_one();
      test_two();
      test_freq();
      conclude();
   end
endmodule
